// ---- core/pfx_pkg.sv ----
// package: register indices, field positions, reset values and modes of the
// port and floppy extended setup registers
// assumes: one 20 MHz clock, synchronous active-low reset
package pfx_pkg;
  // ************************************************************
  // register indices and reset values
  // ************************************************************
  localparam logic [7:0] PFX_IDX_PORT_EXT   = 8'h04;
  localparam logic [7:0] PFX_IDX_FLOPPY_EXT = 8'h05;
  localparam logic [7:0] PFX_PORT_EXT_RST   = 8'h00;
  localparam logic [7:0] PFX_FLOPPY_EXT_RST = 8'h00;
  localparam logic [7:0] PFX_FLOPPY_RW_MASK = 8'h7C;
  // ************************************************************
  // port_extended_setup fields
  // ************************************************************
  localparam int PFX_PE_MODE_LO  = 0;
  localparam int PFX_PE_FOP_LO   = 2;
  localparam int PFX_PE_MUSIC1   = 4;
  localparam int PFX_PE_MUSIC2   = 5;
  localparam int PFX_PE_EPP17    = 6;
  localparam int PFX_PE_ALT_IR   = 7;
  // ************************************************************
  // floppy_extended_setup fields
  // ************************************************************
  localparam int PFX_FE_NONBURST = 2;
  localparam int PFX_FE_SWAP     = 5;
  localparam int PFX_FE_EXT4     = 6;
  // ************************************************************
  // modes and timing
  // ************************************************************
  typedef enum logic [1:0] {
    PFX_PAR_SPP     = 2'b00,
    PFX_PAR_EPP     = 2'b01,
    PFX_PAR_ECP     = 2'b10,
    PFX_PAR_ECP_EPP = 2'b11
  } pfx_par_mode_t;
  typedef enum logic [1:0] {
    PFX_FOP_NORMAL  = 2'b00,
    PFX_FOP_OPT_ONE = 2'b01,
    PFX_FOP_OPT_TWO = 2'b10,
    PFX_FOP_RSVD    = 2'b11
  } pfx_fop_t;
  typedef enum logic [1:0] {
    PFX_OP_SPP = 2'b00,
    PFX_OP_EPP = 2'b01,
    PFX_OP_ECP = 2'b10
  } pfx_op_t;
  localparam logic [2:0] PFX_ECR_SPP  = 3'b000;
  localparam logic [2:0] PFX_ECR_EPP  = 3'b100;
  localparam logic [3:0] PFX_DIV_STD  = 4'hD;
  localparam logic [3:0] PFX_DIV_MUS  = 4'hC;
  localparam logic [4:0] PFX_OVERSAMP = 5'h10;
endpackage

// ---- core/pfx_setup.sv ----
// port and floppy extended setup register pair with the steering they drive
// assumes: host reaches registers through config mode and index register;
// serial reference clock enable pulses arrive on the same CLK domain
//
// Contract
// - port setup at index 04H, resets to 00H
// - bits 1:0 pick parallel mode when unlocked
// - ECP plus EPP: ecr mode 100 gives EPP
// - ECP settings: ecr mode 000 gives standard
// - ECP settings: over two drives needs external decode
// - bits 3:2 floppy on parallel; 11 reserved
// - bit 4: port one divides 12 or 13
// - bit 5: port two divides 12 or 13
// - divide 12 then 16 gives music rate
// - bit 6 picks EPP variant 1.7
// - bit 7 routes infrared to alternate pins
// - alternate pins need zeroth register bits 11
// - floppy setup at index 05H, resets to 00H
// - bit 2 gives per-byte request and interrupt pulses while FIFO enabled
// - bit 5 swaps drive and motor selects
// - bit 6 emits encoded selects for four drives
module pfx_setup
  import pfx_pkg::*;
(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // configuration access
  input  wire logic       CFG_MODE,
  input  wire logic [7:0] CFG_INDEX,
  input  wire logic       CFG_WR,
  input  wire logic       CFG_RD,
  input  wire logic [7:0] CFG_WDATA,
  output logic      [7:0] CFG_RDATA,
  output logic            CFG_RVALID,
  // neighbouring configuration bits
  input  wire logic       FIRST_CFG_BIT3,
  input  wire logic [1:0] ZEROTH_CFG_BITS,
  // parallel port control
  input  wire logic       ECR_WR,
  input  wire logic [2:0] ECR_MODE,
  output logic      [1:0] PAR_OP,
  output logic            EPP_V17,
  output logic      [1:0] FLOPPY_ON_PARALLEL,
  // serial clocks
  input  wire logic       SER_REF_EN,
  output logic            SER1_BAUD16_EN,
  output logic            SER2_BAUD16_EN,
  output logic            MUSIC_PORT_ONE,
  output logic            MUSIC_PORT_TWO,
  // infrared routing
  input  wire logic       INFRARED_TRANSMIT_IN,
  input  wire logic       INFRARED_RECEIVE,
  input  wire logic       ALT_INFRARED_RECEIVE,
  output logic            INFRARED_TRANSMIT,
  output logic            ALT_INFRARED_TRANSMIT,
  output logic            INFRARED_RX_OUT,
  // floppy drive selects and dma
  input  wire logic [1:0] FDC_DRIVE_NUM,
  input  wire logic [1:0] FDC_MOTOR_ON,
  input  wire logic       FDC_BYTE_DONE,
  input  wire logic       FDC_FIFO_EN,
  input  wire logic       FDC_DRQ_BURST,
  input  wire logic       FDC_IRQ_BURST,
  input  wire logic [1:0] DRIVE_COUNT_M1,
  output logic      [1:0] DRIVE_SEL,
  output logic      [1:0] MOTOR_SEL,
  output logic            FLOPPY_DMA_REQUEST,
  output logic            FLOPPY_INTERRUPT,
  output logic            DRIVE_CFG_ERR
);

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] port_ext_r;
  logic [7:0] floppy_ext_r;
  logic       sel_port;
  logic       sel_floppy;

  function automatic logic hit(input logic md, input logic [7:0] idx, input logic [7:0] want);
    hit = md && (idx == want);
  endfunction

  assign sel_port   = hit(CFG_MODE, CFG_INDEX, PFX_IDX_PORT_EXT);
  assign sel_floppy = hit(CFG_MODE, CFG_INDEX, PFX_IDX_FLOPPY_EXT);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      port_ext_r <= PFX_PORT_EXT_RST;
    end else if (CFG_WR && sel_port) begin
      port_ext_r <= CFG_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      floppy_ext_r <= PFX_FLOPPY_EXT_RST;
    end else if (CFG_WR && sel_floppy) begin
      floppy_ext_r <= CFG_WDATA & PFX_FLOPPY_RW_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      CFG_RDATA  <= 8'h00;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RVALID <= CFG_RD && (sel_port || sel_floppy);
      if (CFG_RD && sel_port) begin
        CFG_RDATA <= port_ext_r;
      end else if (CFG_RD && sel_floppy) begin
        CFG_RDATA <= floppy_ext_r & PFX_FLOPPY_RW_MASK;
      end else begin
        CFG_RDATA <= 8'h00;
      end
    end
  end

  // ************************************************************
  // parallel port mode
  // ************************************************************
  pfx_par_mode_t par_mode;
  logic          ecp_based;
  logic [1:0]    op_r;

  assign par_mode  = pfx_par_mode_t'(port_ext_r[PFX_PE_MODE_LO +: 2]);
  assign ecp_based = !FIRST_CFG_BIT3 &&
                     (par_mode == PFX_PAR_ECP || par_mode == PFX_PAR_ECP_EPP);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      op_r <= PFX_OP_SPP;
    end else if (FIRST_CFG_BIT3) begin
      op_r <= PFX_OP_SPP;
    end else begin
      case (par_mode)
        PFX_PAR_SPP: begin
          op_r <= PFX_OP_SPP;
        end
        PFX_PAR_EPP: begin
          op_r <= PFX_OP_EPP;
        end
        default: begin
          if (ECR_WR && ECR_MODE == PFX_ECR_SPP) begin
            op_r <= PFX_OP_SPP;
          end else if (ECR_WR && ECR_MODE == PFX_ECR_EPP && par_mode == PFX_PAR_ECP_EPP) begin
            op_r <= PFX_OP_EPP;
          end else if (ECR_WR || (op_r == PFX_OP_EPP && par_mode != PFX_PAR_ECP_EPP)) begin
            op_r <= PFX_OP_ECP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      PAR_OP             <= PFX_OP_SPP;
      EPP_V17            <= 1'b0;
      FLOPPY_ON_PARALLEL <= PFX_FOP_NORMAL;
    end else begin
      PAR_OP  <= op_r;
      EPP_V17 <= port_ext_r[PFX_PE_EPP17];
      if (pfx_fop_t'(port_ext_r[PFX_PE_FOP_LO +: 2]) == PFX_FOP_RSVD) begin
        FLOPPY_ON_PARALLEL <= PFX_FOP_NORMAL;
      end else begin
        FLOPPY_ON_PARALLEL <= port_ext_r[PFX_PE_FOP_LO +: 2];
      end
    end
  end

  // ************************************************************
  // serial clock dividers
  // ************************************************************
  logic [3:0] div1_r;
  logic [3:0] div2_r;
  logic [3:0] div1_end;
  logic [3:0] div2_end;

  function automatic logic [3:0] div_last(input logic music);
    div_last = (music ? PFX_DIV_MUS : PFX_DIV_STD) - 4'h1;
  endfunction

  assign div1_end = div_last(port_ext_r[PFX_PE_MUSIC1]);
  assign div2_end = div_last(port_ext_r[PFX_PE_MUSIC2]);

  // baud16 enable is the x16 sample rate; receiver divides by 16 more
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      div1_r         <= 4'h0;
      SER1_BAUD16_EN <= 1'b0;
    end else begin
      SER1_BAUD16_EN <= 1'b0;
      if (SER_REF_EN) begin
        if (div1_r >= div1_end) begin
          div1_r         <= 4'h0;
          SER1_BAUD16_EN <= 1'b1;
        end else begin
          div1_r <= div1_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      div2_r         <= 4'h0;
      SER2_BAUD16_EN <= 1'b0;
    end else begin
      SER2_BAUD16_EN <= 1'b0;
      if (SER_REF_EN) begin
        if (div2_r >= div2_end) begin
          div2_r         <= 4'h0;
          SER2_BAUD16_EN <= 1'b1;
        end else begin
          div2_r <= div2_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      MUSIC_PORT_ONE <= 1'b0;
      MUSIC_PORT_TWO <= 1'b0;
    end else begin
      MUSIC_PORT_ONE <= port_ext_r[PFX_PE_MUSIC1];
      MUSIC_PORT_TWO <= port_ext_r[PFX_PE_MUSIC2];
    end
  end

  // ************************************************************
  // infrared routing
  // ************************************************************
  logic ir_rx_s1;
  logic ir_rx_s2;
  logic ir_alt_s1;
  logic ir_alt_s2;
  logic alt_sel;
  logic alt_live;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ir_rx_s1  <= 1'b1;
      ir_rx_s2  <= 1'b1;
      ir_alt_s1 <= 1'b1;
      ir_alt_s2 <= 1'b1;
    end else begin
      ir_rx_s1  <= INFRARED_RECEIVE;
      ir_rx_s2  <= ir_rx_s1;
      ir_alt_s1 <= ALT_INFRARED_RECEIVE;
      ir_alt_s2 <= ir_alt_s1;
    end
  end

  assign alt_sel  = port_ext_r[PFX_PE_ALT_IR];
  assign alt_live = alt_sel && (ZEROTH_CFG_BITS == 2'b11);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      INFRARED_TRANSMIT     <= 1'b0;
      ALT_INFRARED_TRANSMIT <= 1'b0;
      INFRARED_RX_OUT       <= 1'b1;
    end else begin
      INFRARED_TRANSMIT     <= alt_sel ? 1'b0 : INFRARED_TRANSMIT_IN;
      ALT_INFRARED_TRANSMIT <= alt_live ? INFRARED_TRANSMIT_IN : 1'b0;
      if (!alt_sel) begin
        INFRARED_RX_OUT <= ir_rx_s2;
      end else if (alt_live) begin
        INFRARED_RX_OUT <= ir_alt_s2;
      end else begin
        INFRARED_RX_OUT <= 1'b1;
      end
    end
  end

  // ************************************************************
  // floppy selects and dma
  // ************************************************************
  logic       swap;
  logic       ext4;
  logic [1:0] drv;
  logic [1:0] mot;

  assign swap = floppy_ext_r[PFX_FE_SWAP];
  assign ext4 = floppy_ext_r[PFX_FE_EXT4];
  assign drv  = (swap && !FDC_DRIVE_NUM[1]) ? {1'b0, ~FDC_DRIVE_NUM[0]} : FDC_DRIVE_NUM;
  assign mot  = swap ? {FDC_MOTOR_ON[0], FDC_MOTOR_ON[1]} : FDC_MOTOR_ON;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      DRIVE_SEL     <= 2'b00;
      MOTOR_SEL     <= 2'b00;
      DRIVE_CFG_ERR <= 1'b0;
    end else begin
      MOTOR_SEL <= mot;
      if (ext4) begin
        DRIVE_SEL <= drv;
      end else begin
        DRIVE_SEL <= (drv[1]) ? 2'b00 : {drv[0], ~drv[0]};
      end
      DRIVE_CFG_ERR <= ecp_based && DRIVE_COUNT_M1[1] && !ext4;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      FLOPPY_DMA_REQUEST <= 1'b0;
      FLOPPY_INTERRUPT   <= 1'b0;
    end else if (floppy_ext_r[PFX_FE_NONBURST] && FDC_FIFO_EN) begin
      FLOPPY_DMA_REQUEST <= FDC_BYTE_DONE;
      FLOPPY_INTERRUPT   <= FDC_BYTE_DONE;
    end else begin
      FLOPPY_DMA_REQUEST <= FDC_DRQ_BURST;
      FLOPPY_INTERRUPT   <= FDC_IRQ_BURST;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_wr_port;
    CFG_WR && sel_port;
  endsequence

  chk_port_write: assert property (@(posedge CLK) disable iff (!RESETN)
    s_wr_port |=> port_ext_r == $past(CFG_WDATA))
    else $error("port setup write lost");
  chk_port_guard: assert property (@(posedge CLK) disable iff (!RESETN)
    (!CFG_MODE || !(CFG_WR && CFG_INDEX == PFX_IDX_PORT_EXT)) |=> $stable(port_ext_r))
    else $error("port setup changed without access");
  chk_floppy_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    CFG_RD && sel_floppy |=> CFG_RVALID && CFG_RDATA[1:0] == 2'b00 && !CFG_RDATA[7])
    else $error("floppy reserved bits read nonzero");
  chk_epp_entry: assert property (@(posedge CLK) disable iff (!RESETN)
    ECR_WR && ECR_MODE == PFX_ECR_EPP && !FIRST_CFG_BIT3 && par_mode == PFX_PAR_ECP_EPP
    |=> ##1 PAR_OP == PFX_OP_EPP)
    else $error("epp not entered");
  chk_spp_entry: assert property (@(posedge CLK) disable iff (!RESETN)
    ECR_WR && ECR_MODE == PFX_ECR_SPP && ecp_based |=> ##1 PAR_OP == PFX_OP_SPP)
    else $error("spp not entered");
  chk_music_div: assert property (@(posedge CLK) disable iff (!RESETN)
    port_ext_r[PFX_PE_MUSIC1] && $stable(port_ext_r) && div1_r == 4'h0 && SER_REF_EN
    |=> div1_r == 4'h1)
    else $error("port one divider stalled");
  chk_alt_gate: assert property (@(posedge CLK) disable iff (!RESETN)
    alt_sel && ZEROTH_CFG_BITS != 2'b11 |=> !ALT_INFRARED_TRANSMIT)
    else $error("alternate infrared driven while gated");
  chk_dma_pulse: assert property (@(posedge CLK) disable iff (!RESETN)
    floppy_ext_r[PFX_FE_NONBURST] && FDC_FIFO_EN && FDC_BYTE_DONE
    |=> FLOPPY_DMA_REQUEST && FLOPPY_INTERRUPT)
    else $error("non-burst pulse missing");
  chk_swap_motor: assert property (@(posedge CLK) disable iff (!RESETN)
    swap |=> MOTOR_SEL == {$past(FDC_MOTOR_ON[0]), $past(FDC_MOTOR_ON[1])})
    else $error("motor selects not swapped");
  chk_ext_decode: assert property (@(posedge CLK) disable iff (!RESETN)
    ecp_based && DRIVE_COUNT_M1[1] && !ext4 |=> DRIVE_CFG_ERR)
    else $error("drive count error not flagged");

endmodule

// ---- verification/pfx_host.sv ----
// host model: drives config mode, index, strobes and write data
// assumes: strobes sampled on rising CLK, read answer one cycle later
module pfx_host (
  // clock
  input  wire logic       CLK,
  // config bus
  output logic            CFG_MODE,
  output logic      [7:0] CFG_INDEX,
  output logic            CFG_WR,
  output logic            CFG_RD,
  output logic      [7:0] CFG_WDATA,
  input  wire logic [7:0] CFG_RDATA,
  input  wire logic       CFG_RVALID
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {CFG_MODE, CFG_INDEX, CFG_WR, CFG_RD} = '0;
    CFG_WDATA = 8'hA5;
  end
  // one strobe cycle; read data taken at the answering edge
  task automatic access(input logic md, input logic [7:0] idx, input logic wr,
                        input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge CLK);
    CFG_MODE  <= md;
    CFG_INDEX <= idx;
    CFG_WR    <= wr;
    CFG_RD    <= ~wr;
    CFG_WDATA <= d;
    @(posedge CLK);
    CFG_WR    <= 1'b0;
    CFG_RD    <= 1'b0;
    // stale data must not be mistaken for a write
    CFG_WDATA <= ~d;
    #1;
    q = CFG_RDATA;
    v = CFG_RVALID;
  endtask
endmodule

// ---- verification/pfx_setup_tb.sv ----
// testbench: host model plus shadow model of both setup registers
// assumes: 20 MHz CLK, RESETN held low for 20 cycles
module pfx_setup_tb
  import pfx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, resetn, mode, wr_s, rd_s, rvalid, b3, ecr_wr, ref_en, txi, rx, rxa;
  logic [7:0] idx, wdata, rdata, q, d, pe_m, fe_m;
  logic [2:0] ecr_mode;
  logic [1:0] zer, par_op, fop, drv, mot, cnt, dsel, msel, dn;
  logic v, epp17, s1, s2, mus1, mus2, tx, txa, rxo, bd, fifo, drq, irq, req, fint, cerr;
  int err_count, comparisons, cycles, n;
  int em[5] = '{3, 3, 3, 2, 2};
  int ev[5] = '{4, 0, 1, 4, 0};
  int ex[5] = '{1, 0, 2, 2, 0};

  pfx_host pfx_host_inst (.CLK(clk), .CFG_MODE(mode), .CFG_INDEX(idx), .CFG_WR(wr_s),
    .CFG_RD(rd_s), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid));
  pfx_setup pfx_setup_inst (.CLK(clk), .RESETN(resetn), .CFG_MODE(mode), .CFG_INDEX(idx),
    .CFG_WR(wr_s), .CFG_RD(rd_s), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
    .FIRST_CFG_BIT3(b3), .ZEROTH_CFG_BITS(zer), .ECR_WR(ecr_wr), .ECR_MODE(ecr_mode),
    .PAR_OP(par_op), .EPP_V17(epp17), .FLOPPY_ON_PARALLEL(fop), .SER_REF_EN(ref_en),
    .SER1_BAUD16_EN(s1), .SER2_BAUD16_EN(s2), .MUSIC_PORT_ONE(mus1), .MUSIC_PORT_TWO(mus2),
    .INFRARED_TRANSMIT_IN(txi), .INFRARED_RECEIVE(rx), .ALT_INFRARED_RECEIVE(rxa),
    .INFRARED_TRANSMIT(tx), .ALT_INFRARED_TRANSMIT(txa), .INFRARED_RX_OUT(rxo),
    .FDC_DRIVE_NUM(drv), .FDC_MOTOR_ON(mot), .FDC_BYTE_DONE(bd), .FDC_FIFO_EN(fifo),
    .FDC_DRQ_BURST(drq), .FDC_IRQ_BURST(irq), .DRIVE_COUNT_M1(cnt), .DRIVE_SEL(dsel),
    .MOTOR_SEL(msel), .FLOPPY_DMA_REQUEST(req), .FLOPPY_INTERRUPT(fint),
    .DRIVE_CFG_ERR(cerr));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] x);
    pfx_host_inst.access(1'b1, i, 1'b1, x, q, v);
    if (i == PFX_IDX_PORT_EXT) pe_m = x;
    if (i == PFX_IDX_FLOPPY_EXT) fe_m = x & 8'h7C;
  endtask
  task automatic rd(input logic [7:0] i);
    pfx_host_inst.access(1'b1, i, 1'b0, 8'h00, q, v);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic period(input logic p, output int c);
    c = 0;
    do begin
      settle(1);
      c++;
    end while ((p ? s2 : s1) !== 1'b1 && c < 40);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    {resetn, b3, zer, ecr_wr, ecr_mode, txi, rx, drv, mot, bd, drq, irq, cnt} = '0;
    {ref_en, rxa, fifo} = 3'b111;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    void'($urandom(32'h9556));
    rd(PFX_IDX_PORT_EXT);
    check("port_reset", q, 8'h00);
    check("port_valid", v, 1'b1);
    rd(PFX_IDX_FLOPPY_EXT);
    check("floppy_reset", q, 8'h00);
    pfx_host_inst.access(1'b0, PFX_IDX_PORT_EXT, 1'b1, 8'hFF, q, v);
    pfx_host_inst.access(1'b1, 8'h06, 1'b0, 8'h00, q, v);
    check("unmapped_valid", v, 1'b0);
    rd(PFX_IDX_PORT_EXT);
    check("refused_write", q, 8'h00);
    $display("test reset and refusal done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(PFX_IDX_PORT_EXT, d);
      wr(PFX_IDX_FLOPPY_EXT, ~d);
      rd(PFX_IDX_PORT_EXT);
      check("port_readback", q, pe_m);
      rd(PFX_IDX_FLOPPY_EXT);
      check("floppy_readback", q, fe_m);
    end
    $display("test readback done");
    for (int m = 0; m < 16; m++) begin
      wr(PFX_IDX_PORT_EXT, 8'(m | ((m & 1) << 6)));
      settle(3);
      check("par_op", par_op, 8'(((m & 3) == 3) ? 2 : (m & 3)));
      check("floppy_on_par", fop, 8'(((m >> 2) == 3) ? 0 : (m >> 2)));
      check("epp_variant", epp17, 8'(m & 1));
    end
    @(posedge clk);
    b3 <= 1'b1;
    settle(3);
    check("par_op_locked", par_op, 2'b00);
    @(posedge clk);
    b3 <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(PFX_IDX_PORT_EXT, 8'(em[i]));
      @(posedge clk);
      ecr_wr <= 1'b1;
      ecr_mode <= 3'(ev[i]);
      @(posedge clk);
      ecr_wr <= 1'b0;
      ecr_mode <= 3'($urandom);
      settle(3);
      check("ecr_op", par_op, 8'(ex[i]));
    end
    $display("test parallel modes done");
    for (int m = 0; m < 4; m++) begin
      wr(PFX_IDX_PORT_EXT, 8'(m << 4));
      settle(3);
      check("music_one", mus1, 8'(m & 1));
      check("music_two", mus2, 8'(m >> 1));
      for (int p = 0; p < 2; p++) begin
        period(p[0], n);
        period(p[0], n);
        check("baud_period", 8'(n), 8'(((m >> p) & 1) ? 12 : 13));
      end
    end
    // no reference ticks: both dividers must stay quiet
    @(posedge clk);
    ref_en <= 1'b0;
    settle(2);
    repeat (14) begin
      settle(1);
      check("baud_hold", {6'h00, s2, s1}, 8'h00);
    end
    @(posedge clk);
    ref_en <= 1'b1;
    $display("test serial dividers done");
    for (int k = 0; k < 8; k++) begin
      wr(PFX_IDX_PORT_EXT, 8'((k >> 2) << 7));
      @(posedge clk);
      zer <= 2'(k);
      {txi, rx, rxa} <= 3'($urandom);
      settle(5);
      check("alt_tx", txa, (k[2] && k[1:0] == 3) ? txi : 1'b0);
      check("prim_tx", tx, k[2] ? 1'b0 : txi);
      check("rx_out", rxo, !k[2] ? rx : (k[1:0] == 3) ? rxa : 1'b1);
    end
    $display("test infrared routing done");
    wr(PFX_IDX_PORT_EXT, 8'h02);
    for (int i = 0; i < 24; i++) begin
      wr(PFX_IDX_FLOPPY_EXT, 8'($urandom));
      @(posedge clk);
      {drv, mot, cnt, bd, drq, irq, fifo} <= 10'($urandom);
      settle(3);
      dn = (fe_m[5] && !drv[1]) ? drv ^ 2'b01 : drv;
      check("drive_sel", dsel, 8'(fe_m[6] ? dn : (dn == 0) ? 1 : (dn == 1) ? 2 : 0));
      check("motor_sel", msel, fe_m[5] ? {mot[0], mot[1]} : mot);
      check("cfg_err", cerr, pe_m[1] && cnt >= 2 && !fe_m[6]);
      check("dma_req", req, (fe_m[2] && fifo) ? bd : drq);
      check("fdc_int", fint, (fe_m[2] && fifo) ? bd : irq);
    end
    $display("test floppy steering done");
    end_sim();
  end
endmodule
